// ### core/phmp_pkg.sv
package phmp_pkg;
	// ==========================================
	// register addresses on the byte port
	localparam logic [1:0] ADDR_MESSAGE  = 2'h0; // message_pipe
	localparam logic [1:0] ADDR_CONTROL  = 2'h1; // host_control_status
	localparam logic [1:0] ADDR_LINEAR   = 2'h2; // linear_audio_input_register
	localparam logic [1:0] ADDR_COMPRESS = 2'h3; // compressed_input_register
	// ==========================================
	// control register bit positions
	localparam int BIT_CMP_RST  = 6;
	localparam int BIT_PCM_RST  = 5;
	localparam int BIT_AF_C     = 4;
	localparam int BIT_AF_B     = 3;
	localparam int BIT_IN_BUSY  = 2;
	localparam int BIT_OUT_RDY  = 1;
	localparam logic [7:0] CTRL_WR_MASK = 8'h60; // writable bits
	localparam logic [7:0] CTRL_HOST_MASK = 8'h7E; // reserved bits forced 0
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BUS_IDLE   = 8'hFF; // pulled-up bus level
	// ==========================================
	// mode straps: rd high, wr high, select low
	localparam logic [2:0] MODE_STRAP_PAR = 3'h6;
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	// ==========================================
	// host-side apb map and fields
	localparam logic [7:0] APB_CMD    = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam int CMD_READ_BIT = 10;
	localparam int STAT_BUSY_BIT = 8;
	// ==========================================
	// pin timing
	localparam int CLK_NS        = 8;
	localparam int T_SETUP_NS    = 16; // address before strobe
	localparam int T_STROBE_NS   = 96; // strobe low time
	localparam int T_RECOVER_NS  = 40; // idle after strobe
	localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### core/phmp_bus_if.sv
`timescale 1ns/1ps
interface phmp_bus_if;
	// strobes and address from host
	logic       cs_n;
	logic       rd_n;
	logic       wr_n;
	logic       par_select;
	logic [1:0] addr;
	// data drivers of each end
	logic [7:0] host_data;
	logic       host_oe;
	logic [7:0] dev_data;
	logic       dev_oe;
	logic       host_interrupt_request;
	// resolved bus level
	logic [7:0] data;
	assign data = dev_oe ? dev_data : (host_oe ? host_data : phmp_pkg::BUS_IDLE);
	modport device (
		input  cs_n, rd_n, wr_n, par_select, addr, data,
		output dev_data, dev_oe, host_interrupt_request
	);
	modport host (
		input  data, host_interrupt_request,
		output cs_n, rd_n, wr_n, par_select, addr, host_data, host_oe
	);
endinterface

// ### core/phmp_device.sv
// Operation
// - dsp write sets outgoing ready flag
// - host reads with select then read strobe; phmp_host lowers both in the same cycle
// - select and read low drive register
// - host sets address before strobes fall
// - host message read clears outgoing ready
// - write starts when select, write low
// - first strobe rise captures written byte
// - host message write sets incoming busy
// - dsp read clears incoming busy
// - host polls busy before next message
// - decoder reset ignores strobes, releases bus
// - message register is two separate bytes
// - address zero selects message register
// - address one selects control register layout
// - host writes zero to reserved bits
// - compressed port reset bit holds port
// - strap pins latched after reset release
// - interrupt while outgoing byte waits
// - addresses two, three feed input data
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module phmp_device (
	// clock and decoder reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// host pins
	phmp_bus_if.device      bus,
	// dsp side
	input  wire logic [7:0] dsp_out_byte,
	input  wire logic       dsp_out_write,
	input  wire logic       dsp_in_read,
	input  wire logic       almost_full_flag_c,
	input  wire logic       almost_full_flag_b,
	output logic      [7:0] dsp_in_byte,
	output logic            outgoing_ready_flag,
	output logic            incoming_busy_flag,
	output logic            compressed_port_reset,
	output logic            linear_audio_port_reset,
	output logic      [7:0] stream_byte,
	output logic            compressed_valid,
	output logic            linear_audio_valid,
	output logic            parallel_mode
);
	// ==========================================
	// pin synchronisers
	logic [13:0] sync_a;     // first stage, read only by second
	logic [13:0] sync_b;     // second stage
	logic        s_cs_n;     // synchronised chip select
	logic        s_rd_n;     // synchronised read strobe
	logic        s_wr_n;     // synchronised write strobe
	logic        s_psel;     // synchronised select strap
	logic [1:0]  s_addr;     // synchronised address
	logic [7:0]  s_data;     // synchronised data bus
	// two flops on every pin; idle levels at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 14'h38FF;
			sync_b <= 14'h38FF;
		end else begin
			sync_a <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.par_select, bus.addr, bus.data};
			sync_b <= sync_a;
		end
	end
	assign {s_cs_n, s_rd_n, s_wr_n, s_psel, s_addr, s_data} = sync_b;

	// ==========================================
	// strap capture after reset release
	logic [1:0] strap_cnt;   // waits until synchronisers hold real pins
	logic       strap_done;  // strap sampled
	// straps are read once the pipeline is filled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt     <= 2'h0;
			strap_done    <= 1'b0;
			parallel_mode <= 1'b0;
		end else if (!strap_done) begin
			if (strap_cnt == phmp_pkg::STRAP_WAIT) begin
				strap_done    <= 1'b1;
				parallel_mode <= ({s_rd_n, s_wr_n, s_psel} == phmp_pkg::MODE_STRAP_PAR);
			end else begin
				strap_cnt <= strap_cnt + 2'h1;
			end
		end
	end

	// ==========================================
	// access decode
	logic       wr_act;      // write cycle open now
	logic       rd_act;      // read cycle open now
	logic       wr_act_q;    // write cycle open last cycle
	logic       rd_act_q;    // read cycle open last cycle
	logic [1:0] wr_addr;     // address held during write
	logic [7:0] wr_data;     // data held during write
	logic [1:0] rd_addr;     // address held during read
	logic       wr_end;      // first rising strobe ends write
	logic       rd_end;      // read cycle closed
	// strobes count only in parallel mode with select low
	assign wr_act = parallel_mode && !s_cs_n && !s_wr_n;
	assign rd_act = parallel_mode && !s_cs_n && !s_rd_n;
	assign wr_end = wr_act_q && !wr_act;
	assign rd_end = rd_act_q && !rd_act;

	// track open cycles and hold the last values seen inside them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			wr_addr  <= 2'h0;
			wr_data  <= 8'h00;
			rd_addr  <= 2'h0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			// address is stable before strobes fall
			if (wr_act) begin
				wr_addr <= s_addr;
				wr_data <= s_data;
			end
			if (rd_act) begin
				rd_addr <= s_addr;
			end
		end
	end

	// ==========================================
	// message pipe, two independent bytes
	logic [7:0] msg_out;     // dsp to host byte
	// dsp to host half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_out <= 8'h00;
		end else if (dsp_out_write) begin
			msg_out <= dsp_out_byte;
		end
	end
	// host to dsp half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dsp_in_byte <= 8'h00;
		end else if (wr_end && wr_addr == phmp_pkg::ADDR_MESSAGE) begin
			dsp_in_byte <= wr_data;
		end
	end

	// ==========================================
	// handshake flags, set beats clear
	logic host_msg_read;     // host finished reading message
	logic host_msg_write;    // host finished writing message
	assign host_msg_read  = rd_end && rd_addr == phmp_pkg::ADDR_MESSAGE;
	assign host_msg_write = wr_end && wr_addr == phmp_pkg::ADDR_MESSAGE;
	// outgoing ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outgoing_ready_flag <= 1'b0;
		end else if (dsp_out_write) begin
			outgoing_ready_flag <= 1'b1;
		end else if (host_msg_read) begin
			outgoing_ready_flag <= 1'b0;
		end
	end
	// incoming busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			incoming_busy_flag <= 1'b0;
		end else if (host_msg_write) begin
			incoming_busy_flag <= 1'b1;
		end else if (dsp_in_read) begin
			incoming_busy_flag <= 1'b0;
		end
	end
	// interrupt follows a waiting outgoing byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.host_interrupt_request <= 1'b0;
		end else begin
			bus.host_interrupt_request <= outgoing_ready_flag;
		end
	end

	// ==========================================
	// control register port resets
	// write-only bits; reserved bits dropped, flags not writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compressed_port_reset   <= phmp_pkg::CTRL_RESET[phmp_pkg::BIT_CMP_RST];
			linear_audio_port_reset <= phmp_pkg::CTRL_RESET[phmp_pkg::BIT_PCM_RST];
		end else if (wr_end && wr_addr == phmp_pkg::ADDR_CONTROL) begin
			compressed_port_reset   <= wr_data[phmp_pkg::BIT_CMP_RST];
			linear_audio_port_reset <= wr_data[phmp_pkg::BIT_PCM_RST];
		end
	end

	// ==========================================
	// data input registers
	// one-cycle byte strobes; a port held in reset drops its bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stream_byte        <= 8'h00;
			compressed_valid   <= 1'b0;
			linear_audio_valid <= 1'b0;
		end else begin
			compressed_valid   <= wr_end && wr_addr == phmp_pkg::ADDR_COMPRESS
				&& !compressed_port_reset;
			linear_audio_valid <= wr_end && wr_addr == phmp_pkg::ADDR_LINEAR
				&& !linear_audio_port_reset;
			if (wr_end) begin
				stream_byte <= wr_data;
			end
		end
	end

	// ==========================================
	// read path
	logic [7:0] ctrl_view;   // control register as read
	logic [7:0] rd_mux;      // selected register
	// flags and almost-full inputs; write-only and reserved read 0
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[phmp_pkg::BIT_AF_C]    = almost_full_flag_c;
		ctrl_view[phmp_pkg::BIT_AF_B]    = almost_full_flag_b;
		ctrl_view[phmp_pkg::BIT_IN_BUSY] = incoming_busy_flag;
		ctrl_view[phmp_pkg::BIT_OUT_RDY] = outgoing_ready_flag;
	end
	// address decode; input registers are write only
	always_comb begin
		if (s_addr == phmp_pkg::ADDR_MESSAGE) begin
			rd_mux = msg_out;
		end else if (s_addr == phmp_pkg::ADDR_CONTROL) begin
			rd_mux = ctrl_view;
		end else begin
			rd_mux = 8'h00;
		end
	end
	// drive bus one cycle behind the decoded read cycle, never in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.dev_oe   <= 1'b0;
			bus.dev_data <= 8'h00;
		end else begin
			bus.dev_oe   <= rd_act;
			bus.dev_data <= rd_mux;
		end
	end
endmodule // phmp_device

// ### core/phmp_host.sv
`timescale 1ns/1ps
module phmp_host (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// device pins
	phmp_bus_if.host         bus
);
	// ==========================================
	// state machine
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_SETUP   = 4'b0010,
		ST_STROBE  = 4'b0100,
		ST_RECOVER = 4'b1000
	} phmp_state_t;
	phmp_state_t state;       // transfer phase
	logic [3:0]  cnt;         // phase cycle count
	logic        is_read;     // current access reads
	logic [7:0]  rd_byte;     // last byte read
	logic [7:0]  sync_a;      // data pin first stage
	logic [7:0]  sync_b;      // data pin second stage
	logic [1:0]  irq_sync;    // interrupt two-stage
	logic        cmd_write;   // apb write to command word
	logic        busy;        // transfer in progress

	assign busy = (state != ST_IDLE);
	assign cmd_write = psel && penable && pwrite && paddr == phmp_pkg::APB_CMD;

	// ==========================================
	// apb slave, zero wait
	// one-cycle access; unmapped reads give 0 and an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr != phmp_pkg::APB_CMD
				&& paddr != phmp_pkg::APB_STATUS;
			if (psel && !penable && !pwrite && paddr == phmp_pkg::APB_STATUS) begin
				prdata <= {22'h0, irq_sync[1], busy, rd_byte};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ==========================================
	// synchronisers on pins from the device
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a   <= 8'h00;
			sync_b   <= 8'h00;
			irq_sync <= 2'h0;
		end else begin
			sync_a   <= bus.data;
			sync_b   <= sync_a;
			irq_sync <= {irq_sync[0], bus.host_interrupt_request};
		end
	end

	// ==========================================
	// pin sequencer; commands while busy are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state         <= ST_IDLE;
			cnt           <= 4'h0;
			is_read       <= 1'b0;
			rd_byte       <= 8'h00;
			bus.cs_n      <= 1'b1;
			bus.rd_n      <= 1'b1;
			bus.wr_n      <= 1'b1;
			bus.par_select <= 1'b0;
			bus.addr      <= 2'h0;
			bus.host_data <= 8'h00;
			bus.host_oe   <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmd_write) begin
						is_read  <= pwdata[phmp_pkg::CMD_READ_BIT];
						bus.addr <= pwdata[9:8];
						// reserved control bits always go out as 0
						if (pwdata[9:8] == phmp_pkg::ADDR_CONTROL) begin
							bus.host_data <= pwdata[7:0] & phmp_pkg::CTRL_HOST_MASK;
						end else begin
							bus.host_data <= pwdata[7:0];
						end
						bus.host_oe <= !pwdata[phmp_pkg::CMD_READ_BIT];
						cnt   <= 4'(phmp_pkg::SETUP_CYC - 1);
						state <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt == 4'h0) begin
						bus.cs_n <= 1'b0;
						bus.rd_n <= !is_read;
						bus.wr_n <= is_read;
						cnt   <= 4'(phmp_pkg::STROBE_CYC - 1);
						state <= ST_STROBE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				ST_STROBE: begin
					if (cnt == 4'h0) begin
						// status polls are reads of the control byte
						if (is_read) begin
							rd_byte <= sync_b;
						end
						bus.cs_n <= 1'b1;
						bus.rd_n <= 1'b1;
						bus.wr_n <= 1'b1;
						cnt   <= 4'(phmp_pkg::RECOVER_CYC - 1);
						state <= ST_RECOVER;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				ST_RECOVER: begin
					bus.host_oe <= 1'b0;
					if (cnt == 4'h0) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // phmp_host

// ### verif/phmp_chk.sv
`timescale 1ns/1ps
module phmp_chk (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// strobes and address
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic       par_select,
	input wire logic [1:0] addr,
	// data drivers
	input wire logic       host_oe,
	input wire logic [7:0] dev_data,
	input wire logic       dev_oe
);
	// ========
	// pin timing and drive rules
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// reset keeps every pin quiet, so this one is not disabled by it
	a_reset_pins_idle: assert property (
		disable iff (1'b0) !presetn |-> cs_n && rd_n && wr_n && !dev_oe)
		else $error("pins active in reset");
	// mode straps must read parallel at release
	a_strap_at_release: assert property (
		$rose(presetn) |-> rd_n && wr_n && !par_select)
		else $error("strap wrong at release");
	// device only drives after select and read stay low
	a_drive_on_read: assert property (
		$rose(dev_oe) |-> !cs_n && !rd_n && $past(!cs_n && !rd_n, 2))
		else $error("data driven without read");
	a_release_bus: assert property ($rose(cs_n) |-> ##[1:6] !dev_oe)
		else $error("data bus not released");
	// no contention while the host writes
	a_quiet_on_write: assert property (!wr_n |-> !dev_oe)
		else $error("device drives during write");
	a_host_drives_wr: assert property (!cs_n && !wr_n |-> host_oe)
		else $error("host not driving write data");
	// address settles two cycles before select falls
	a_addr_setup: assert property (
		$fell(cs_n) |-> $stable(addr) && $past(addr, 2) == addr)
		else $error("address not set up");
	// strobe stays low long enough, then ends in bounded time
	a_strobe_width: assert property (
		$fell(cs_n) |-> (!cs_n) [*8] ##[1:12] cs_n)
		else $error("strobe width wrong");
	// reserved and write-only control bits read back as zero
	a_ctrl_reserved: assert property (
		dev_oe && !cs_n && !rd_n && addr == phmp_pkg::ADDR_CONTROL
		|-> dev_data[7:5] == 3'b000 && !dev_data[0])
		else $error("control reserved bits set");
	// main traffic kinds
	c_msg_read: cover property ($rose(dev_oe) && addr == phmp_pkg::ADDR_MESSAGE);
	c_msg_write: cover property ($fell(wr_n) && addr == phmp_pkg::ADDR_MESSAGE);
	c_ctrl_read: cover property ($rose(dev_oe) && addr == phmp_pkg::ADDR_CONTROL);
endmodule // phmp_chk

// ### verif/parallel_host_message_port_tb.sv
`timescale 1ns/1ps
module parallel_host_message_port_tb;
	// ========
	// stimulus and observed signals
	logic        pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, dsp_out_byte = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic        dsp_out_write = 1'b0, dsp_in_read = 1'b0;
	logic        almost_full_flag_c = 1'b0, almost_full_flag_b = 1'b0;
	logic        pready, pslverr, e, outgoing_ready_flag, incoming_busy_flag, parallel_mode;
	logic        compressed_port_reset, linear_audio_port_reset, compressed_valid;
	logic        linear_audio_valid;
	logic [7:0]  dsp_in_byte, stream_byte, b, w, q, last_cmp, last_lin;
	int          num_errors = 0, n_compared = 0, n_cmp = 0, n_lin = 0, i, c0, l0;
	phmp_bus_if  bus_if ();
	// ========
	// both ends and the checker
	phmp_device u_phmp_device (.pclk, .presetn, .bus(bus_if), .dsp_out_byte, .dsp_out_write,
		.dsp_in_read, .almost_full_flag_c, .almost_full_flag_b, .dsp_in_byte,
		.outgoing_ready_flag, .incoming_busy_flag, .compressed_port_reset,
		.linear_audio_port_reset, .stream_byte, .compressed_valid, .linear_audio_valid,
		.parallel_mode);
	phmp_host u_phmp_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .bus(bus_if));
	phmp_chk u_phmp_chk (.pclk, .presetn, .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
		.wr_n(bus_if.wr_n), .par_select(bus_if.par_select), .addr(bus_if.addr),
		.host_oe(bus_if.host_oe), .dev_data(bus_if.dev_data), .dev_oe(bus_if.dev_oe));
	always #4 pclk = ~pclk;
	// count bytes leaving the input ports
	always @(posedge pclk) begin
		if (compressed_valid === 1'b1) begin
			n_cmp++;
			last_cmp = stream_byte;
		end
		if (linear_audio_valid === 1'b1) begin
			n_lin++;
			last_lin = stream_byte;
		end
	end
	// ========
	// helpers
	function automatic logic [31:0] ctrl_exp(input logic bsy, input logic rdy);
		return {24'h00_0000, 3'b000, almost_full_flag_c, almost_full_flag_b, bsy, rdy, 1'b0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// one apb transfer; answer taken at the rising edge where pready is high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		if (n >= 20) begin
			num_errors++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// one pin access through the command register, polled to completion
	task automatic pin(input logic rd, input logic [1:0] a, input logic [7:0] d);
		int n;
		apb(1'b1, phmp_pkg::APB_CMD, {21'h00_0000, rd, a, d});
		n = 0;
		do begin
			apb(1'b0, phmp_pkg::APB_STATUS, 32'h0000_0000);
			n++;
		end while (r[phmp_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 40);
		q = r[7:0];
		if (n >= 40) begin
			num_errors++;
			wrap_up();
		end
	endtask
	// ========
	// main sequence
	initial begin
		presetn <= 1'b0;
		void'($urandom(78));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("parallel_mode", 1, parallel_mode);
		chk("port resets", 0, {compressed_port_reset, linear_audio_port_reset});
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("unmapped pslverr", 1, e);
		chk("unmapped prdata", 0, r);
		// message traffic both ways, all-ones byte first
		for (i = 0; i < 6; i++) begin
			b = 8'($urandom);
			w = (i == 0) ? 8'hFF : 8'($urandom);
			almost_full_flag_c <= 1'($urandom);
			almost_full_flag_b <= 1'($urandom);
			dsp_out_byte <= b;
			dsp_out_write <= 1'b1;
			@(posedge pclk);
			dsp_out_write <= 1'b0;
			@(posedge pclk);
			chk("outgoing ready", 1, outgoing_ready_flag);
			chk("busy before write", 0, incoming_busy_flag);
			pin(1'b0, phmp_pkg::ADDR_MESSAGE, w);
			chk("incoming busy", 1, incoming_busy_flag);
			chk("dsp_in_byte", w, dsp_in_byte);
			pin(1'b1, phmp_pkg::ADDR_CONTROL, 8'h00);
			chk("control", ctrl_exp(1'b1, 1'b1), q);
			chk("status pslverr", 0, e);
			pin(1'b1, phmp_pkg::ADDR_CONTROL, 8'h00);
			chk("control again", ctrl_exp(1'b1, 1'b1), q);
			apb(1'b0, phmp_pkg::APB_STATUS, 32'h0000_0000);
			chk("interrupt", 1, r[9]);
			pin(1'b1, phmp_pkg::ADDR_MESSAGE, 8'h00);
			chk("message read", b, q);
			chk("outgoing ready", 0, outgoing_ready_flag);
			dsp_in_read <= 1'b1;
			@(posedge pclk);
			dsp_in_read <= 1'b0;
			@(posedge pclk);
			chk("incoming busy", 0, incoming_busy_flag);
		end
		// every port reset combination against input-port traffic
		for (i = 0; i < 4; i++) begin
			pin(1'b0, phmp_pkg::ADDR_CONTROL, 8'(i << 5));
			chk("port resets", i, {compressed_port_reset, linear_audio_port_reset});
			pin(1'b1, phmp_pkg::ADDR_CONTROL, 8'h00);
			chk("control resets hidden", ctrl_exp(1'b0, 1'b0), q);
			c0 = n_cmp;
			l0 = n_lin;
			b = 8'($urandom);
			pin(1'b0, phmp_pkg::ADDR_COMPRESS, b);
			pin(1'b0, phmp_pkg::ADDR_LINEAR, ~b);
			chk("compressed bytes", c0 + (i < 2), n_cmp);
			chk("linear bytes", l0 + (i % 2 == 0), n_lin);
			if (i == 0) chk("stream bytes", {b, ~b}, {last_cmp, last_lin});
		end
		pin(1'b0, phmp_pkg::ADDR_CONTROL, 8'h00);
		// reset in the middle of a read
		apb(1'b1, phmp_pkg::APB_CMD, {21'h00_0000, 1'b1, phmp_pkg::ADDR_CONTROL, 8'h00});
		for (i = 0; i < 20 && bus_if.dev_oe !== 1'b1; i++) @(posedge pclk);
		chk("drive during read", 1, bus_if.dev_oe);
		presetn <= 1'b0;
		@(negedge pclk);
		chk("bus in reset", phmp_pkg::BUS_IDLE, bus_if.data);
		chk("strobes in reset", 3'b111, {bus_if.cs_n, bus_if.rd_n, bus_if.wr_n});
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("mode after reset", 1, parallel_mode);
		pin(1'b0, phmp_pkg::ADDR_MESSAGE, 8'h5A);
		chk("busy after reset", 1, incoming_busy_flag);
		wrap_up();
	end
endmodule // parallel_host_message_port_tb
